// >>> hw/exc_dispatch_pkg.sv
package exc_dispatch_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int WORD_W = 16;
  localparam int VEC_W = 8;

  // ---------------------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------------------
  localparam int TRACE_PENDING_BIT_POS = 1;
  localparam int TRACE_ENABLE_BIT_POS = 2;
  localparam int USER_MODE_BIT_POS = 8;
  localparam int GLOBAL_INTERRUPT_MASK_BIT_POS = 11;
  localparam logic [WORD_W-1:0] PSR_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // Stack frame layout, relative to the new stack pointer
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FRAME_SIZE = 24'h000006;
  localparam logic [ADDR_W-1:0] FRAME_PSR_OFS = 24'h000004;
  localparam logic [ADDR_W-1:0] FRAME_PCH_OFS = 24'h000002;
  localparam logic [ADDR_W-1:0] FRAME_PCL_OFS = 24'h000000;
  localparam logic [ADDR_W-1:0] WORD_STEP = 24'h000002;

  // ---------------------------------------------------------------------------
  // Acknowledge cycle addresses
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ACK_MASKABLE = 24'hFFFE00;
  localparam logic [ADDR_W-1:0] ACK_NMI = 24'hFFFF00;
  localparam logic [ADDR_W-1:0] ACK_EMU = 24'hFFFC00;
  localparam logic [ADDR_W-1:0] ACK_ALT_DEBUG = 24'hFFFC02;
  localparam logic [ADDR_W-1:0] ACK_ALT_TRACE = 24'hFFFC0C;
  localparam logic [ADDR_W-1:0] ACK_ALT_BPT = 24'hFFFC0E;

  // ---------------------------------------------------------------------------
  // Fixed dispatch vectors
  // ---------------------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_NMI = 8'h01;
  localparam logic [VEC_W-1:0] VEC_EMU = 8'h0F;
  localparam logic [VEC_W-1:0] VEC_SVC = 8'h02;
  localparam logic [VEC_W-1:0] VEC_DVZ = 8'h03;
  localparam logic [VEC_W-1:0] VEC_FLG = 8'h04;
  localparam logic [VEC_W-1:0] VEC_BPT = 8'h05;
  localparam logic [VEC_W-1:0] VEC_TRC = 8'h06;
  localparam logic [VEC_W-1:0] VEC_UND = 8'h07;
  localparam logic [VEC_W-1:0] VEC_IAD = 8'h08;
  localparam logic [VEC_W-1:0] VEC_DBG = 8'h09;
  localparam logic [VEC_W-1:0] VEC_NONE = 8'h00;

  // ---------------------------------------------------------------------------
  // Exception kinds
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    EXC_NMI, EXC_MASKABLE, EXC_EMU, EXC_TRACE, EXC_IAD, EXC_DEBUG,
    EXC_BPT, EXC_DVZ, EXC_FLG, EXC_SVC, EXC_UND
  } exc_kind_e;

  function automatic logic is_interrupt(input exc_kind_e k);
    is_interrupt = (k == EXC_NMI) || (k == EXC_MASKABLE) || (k == EXC_EMU);
  endfunction

  function automatic logic suspends_insn(input exc_kind_e k);
    suspends_insn = (k == EXC_BPT) || (k == EXC_DVZ) || (k == EXC_FLG) ||
                    (k == EXC_SVC) || (k == EXC_UND);
  endfunction

  function automatic logic [VEC_W-1:0] fixed_vector(input exc_kind_e k);
    case (k)
      EXC_NMI: fixed_vector = VEC_NMI;
      EXC_EMU: fixed_vector = VEC_EMU;
      EXC_SVC: fixed_vector = VEC_SVC;
      EXC_DVZ: fixed_vector = VEC_DVZ;
      EXC_FLG: fixed_vector = VEC_FLG;
      EXC_BPT: fixed_vector = VEC_BPT;
      EXC_TRACE: fixed_vector = VEC_TRC;
      EXC_UND: fixed_vector = VEC_UND;
      EXC_IAD: fixed_vector = VEC_IAD;
      EXC_DEBUG: fixed_vector = VEC_DBG;
      default: fixed_vector = VEC_NONE;
    endcase
  endfunction

endpackage

// >>> hw/exc_classify.sv
`timescale 1ns/1ps
module exc_classify
  import exc_dispatch_pkg::*;
(
  // Exception being served
  input exc_kind_e kind_i,
  // Alternate acknowledge enables
  input wire logic alt_debug_ack_enable_i,
  input wire logic alt_trace_ack_enable_i,
  input wire logic alt_breakpoint_ack_enable_i,
  // Decoded attributes
  output logic clear_mask_o,
  output logic do_ack_o,
  output logic [ADDR_W-1:0] ack_addr_o
);

  always_comb begin
    clear_mask_o = is_interrupt(kind_i) || (kind_i == EXC_DEBUG) || (kind_i == EXC_IAD);
    do_ack_o = 1'b0;
    ack_addr_o = ACK_MASKABLE;
    case (kind_i)
      EXC_MASKABLE: begin
        do_ack_o = 1'b1;
        ack_addr_o = ACK_MASKABLE;
      end
      EXC_NMI: begin
        do_ack_o = 1'b1;
        ack_addr_o = ACK_NMI;
      end
      EXC_EMU: begin
        do_ack_o = 1'b1;
        ack_addr_o = ACK_EMU;
      end
      EXC_DEBUG: begin
        do_ack_o = alt_debug_ack_enable_i;
        ack_addr_o = ACK_ALT_DEBUG;
      end
      EXC_TRACE: begin
        do_ack_o = alt_trace_ack_enable_i;
        ack_addr_o = ACK_ALT_TRACE;
      end
      EXC_BPT: begin
        do_ack_o = alt_breakpoint_ack_enable_i;
        ack_addr_o = ACK_ALT_BPT;
      end
      default: begin
        do_ack_o = 1'b0;
        ack_addr_o = ACK_MASKABLE;
      end
    endcase
  end

endmodule // exc_classify

// >>> hw/exception_dispatch_unit.sv
`timescale 1ns/1ps
module exception_dispatch_unit
  import exc_dispatch_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Core sequencing
  input wire logic insn_boundary_i,
  input wire logic insn_start_i,
  input wire logic exc_req_i,
  input exc_kind_e exc_kind_i,
  input wire logic [ADDR_W-1:0] cur_pc_i,
  input wire logic [ADDR_W-1:0] next_pc_i,
  input wire logic [ADDR_W-1:0] interrupt_stack_pointer_i,
  // Processor registers
  input wire logic [WORD_W-1:0] dispatch_base_high_i,
  input wire logic [WORD_W-1:0] dispatch_base_low_i,
  input wire logic dispatch_entry_width_select_i,
  input wire logic alt_debug_ack_enable_i,
  input wire logic alt_trace_ack_enable_i,
  input wire logic alt_breakpoint_ack_enable_i,
  input wire logic psr_wr_i,
  input wire logic [WORD_W-1:0] psr_wdata_i,
  // Return from exception
  input wire logic return_from_exception_i,
  input wire logic [ADDR_W-1:0] return_from_exception_pc_i,
  input wire logic [WORD_W-1:0] return_from_exception_global_interrupt_mask_bit,
  // System bus
  input wire logic bus_ack_i,
  input wire logic [WORD_W-1:0] bus_rdata_i,
  output logic bus_req_o,
  output logic bus_we_o,
  output logic bus_byte_o,
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic [WORD_W-1:0] bus_wdata_o,
  // Results to the core
  output logic exc_ack_o,
  output logic suspend_o,
  output logic busy_o,
  output logic done_o,
  output logic [WORD_W-1:0] processor_status_word_o,
  output logic [ADDR_W-1:0] interrupt_stack_pointer_o,
  output logic pc_load_o,
  output logic [ADDR_W-1:0] pc_o
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH_PSR, ST_PUSH_PCL, ST_PUSH_PCH, ST_ACK, ST_READ_LO, ST_READ_HI
  } state_e;

  state_e state_r, state_nxt;
  exc_kind_e kind_r, kind_nxt;
  logic [WORD_W-1:0] psr_r, psr_nxt;
  logic [WORD_W-1:0] psr_stk_r, psr_stk_nxt;
  logic [ADDR_W-1:0] pc_stk_r, pc_stk_nxt;
  logic [ADDR_W-1:0] isp_r, isp_nxt;
  logic [VEC_W-1:0] vec_r, vec_nxt;
  logic [WORD_W-1:0] entry_lo_r, entry_lo_nxt;
  logic wide_r, wide_nxt;
  logic bus_req_r, bus_req_nxt;
  logic bus_we_r, bus_we_nxt;
  logic bus_byte_r, bus_byte_nxt;
  logic [ADDR_W-1:0] bus_addr_r, bus_addr_nxt;
  logic [WORD_W-1:0] bus_wdata_r, bus_wdata_nxt;
  logic exc_ack_r, exc_ack_nxt;
  logic suspend_r, suspend_nxt;
  logic done_r, done_nxt;
  logic pc_load_r, pc_load_nxt;
  logic [ADDR_W-1:0] pc_r, pc_nxt;
  logic busy_r, busy_nxt;
  logic [2*WORD_W-1:0] base_pair;

  logic clear_mask;
  logic do_ack;
  logic [ADDR_W-1:0] ack_addr;
  logic [ADDR_W-1:0] table_base;
  logic [ADDR_W-1:0] entry_addr;
  logic take_req;
  logic take_trace;

  exc_classify u_classify (
    .kind_i(kind_r),
    .alt_debug_ack_enable_i(alt_debug_ack_enable_i),
    .alt_trace_ack_enable_i(alt_trace_ack_enable_i),
    .alt_breakpoint_ack_enable_i(alt_breakpoint_ack_enable_i),
    .clear_mask_o(clear_mask),
    .do_ack_o(do_ack),
    .ack_addr_o(ack_addr)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  assign base_pair = {dispatch_base_high_i, dispatch_base_low_i};
  assign table_base = base_pair[ADDR_W-1:0];
  // Wide entries are four bytes apart, narrow entries two.
  // The vector just read in an acknowledge cycle must already steer the entry address.
  assign entry_addr = table_base + (wide_r ? ADDR_W'({vec_nxt, 2'b00}) : ADDR_W'({vec_nxt, 1'b0}));
  // Interrupts are accepted only between instructions, suspending traps only inside one.
  assign take_req = exc_req_i && (insn_boundary_i != suspends_insn(exc_kind_i));
  assign take_trace = insn_boundary_i && psr_r[TRACE_PENDING_BIT_POS] && !(exc_req_i && !suspends_insn(exc_kind_i));

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    psr_nxt = psr_r;
    psr_stk_nxt = psr_stk_r;
    pc_stk_nxt = pc_stk_r;
    isp_nxt = isp_r;
    vec_nxt = vec_r;
    entry_lo_nxt = entry_lo_r;
    wide_nxt = wide_r;
    exc_ack_nxt = 1'b0;
    suspend_nxt = 1'b0;
    done_nxt = 1'b0;
    pc_load_nxt = 1'b0;
    pc_nxt = pc_r;
    case (state_r)
      ST_IDLE: begin
        if (take_req || take_trace) begin
          kind_nxt = take_req ? exc_kind_i : EXC_TRACE;
          exc_ack_nxt = 1'b1;
          suspend_nxt = take_req && suspends_insn(exc_kind_i);
          // Suspended traps stack their own address, others the following one.
          pc_stk_nxt = suspend_nxt ? cur_pc_i : next_pc_i;
          isp_nxt = interrupt_stack_pointer_i - FRAME_SIZE;
          vec_nxt = fixed_vector(kind_nxt);
          wide_nxt = dispatch_entry_width_select_i;
          psr_stk_nxt = psr_r;
          if (!take_req) begin
            psr_stk_nxt[TRACE_PENDING_BIT_POS] = 1'b0;
            psr_nxt[TRACE_PENDING_BIT_POS] = 1'b0;
          end
          state_nxt = ST_PUSH_PSR;
        end else if (return_from_exception_i) begin
          psr_nxt = return_from_exception_global_interrupt_mask_bit;
          pc_nxt = return_from_exception_pc_i;
          pc_load_nxt = 1'b1;
        end else if (psr_wr_i) begin
          psr_nxt = psr_wdata_i;
        end else if (insn_start_i) begin
          psr_nxt[TRACE_PENDING_BIT_POS] = psr_r[TRACE_ENABLE_BIT_POS];
        end
      end
      ST_PUSH_PSR: begin
        if (bus_ack_i) begin
          psr_nxt[TRACE_PENDING_BIT_POS] = 1'b0;
          psr_nxt[TRACE_ENABLE_BIT_POS] = 1'b0;
          psr_nxt[USER_MODE_BIT_POS] = 1'b0;
          if (clear_mask) begin
            psr_nxt[GLOBAL_INTERRUPT_MASK_BIT_POS] = 1'b0;
          end
          state_nxt = ST_PUSH_PCL;
        end
      end
      ST_PUSH_PCL: begin
        if (bus_ack_i) begin
          state_nxt = ST_PUSH_PCH;
        end
      end
      ST_PUSH_PCH: begin
        if (bus_ack_i) begin
          state_nxt = do_ack ? ST_ACK : ST_READ_LO;
        end
      end
      ST_ACK: begin
        if (bus_ack_i) begin
          if (kind_r == EXC_MASKABLE) begin
            vec_nxt = bus_rdata_i[VEC_W-1:0];
          end
          state_nxt = ST_READ_LO;
        end
      end
      ST_READ_LO: begin
        if (bus_ack_i) begin
          entry_lo_nxt = bus_rdata_i;
          if (wide_r) begin
            state_nxt = ST_READ_HI;
          end else begin
            pc_nxt = {{(ADDR_W-WORD_W-1){1'b0}}, bus_rdata_i, 1'b0};
            pc_load_nxt = 1'b1;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_READ_HI: begin
        if (bus_ack_i) begin
          pc_nxt = {bus_rdata_i[ADDR_W-WORD_W-2:0], entry_lo_r, 1'b0};
          pc_load_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Bus outputs follow the state being entered, so a new transfer starts right after an ack.
  always_comb begin
    busy_nxt = (state_nxt != ST_IDLE);
    bus_req_nxt = 1'b1;
    bus_we_nxt = 1'b0;
    bus_byte_nxt = 1'b0;
    bus_addr_nxt = bus_addr_r;
    bus_wdata_nxt = bus_wdata_r;
    case (state_nxt)
      ST_PUSH_PSR: begin
        bus_we_nxt = 1'b1;
        bus_addr_nxt = isp_nxt + FRAME_PSR_OFS;
        bus_wdata_nxt = psr_stk_nxt;
      end
      ST_PUSH_PCL: begin
        bus_we_nxt = 1'b1;
        bus_addr_nxt = isp_r + FRAME_PCL_OFS;
        bus_wdata_nxt = pc_stk_r[WORD_W-1:0];
      end
      ST_PUSH_PCH: begin
        bus_we_nxt = 1'b1;
        bus_addr_nxt = isp_r + FRAME_PCH_OFS;
        bus_wdata_nxt = WORD_W'(pc_stk_r[ADDR_W-1:WORD_W]);
      end
      ST_ACK: begin
        bus_byte_nxt = 1'b1;
        bus_addr_nxt = ack_addr;
      end
      ST_READ_LO: begin
        bus_addr_nxt = entry_addr;
      end
      ST_READ_HI: begin
        bus_addr_nxt = entry_addr + WORD_STEP;
      end
      default: begin
        bus_req_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_IDLE;
      kind_r <= EXC_NMI;
      psr_r <= PSR_RESET;
      psr_stk_r <= PSR_RESET;
      pc_stk_r <= '0;
      isp_r <= '0;
      vec_r <= VEC_NONE;
      entry_lo_r <= '0;
      wide_r <= 1'b0;
      bus_req_r <= 1'b0;
      bus_we_r <= 1'b0;
      bus_byte_r <= 1'b0;
      bus_addr_r <= '0;
      bus_wdata_r <= '0;
      exc_ack_r <= 1'b0;
      suspend_r <= 1'b0;
      done_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      psr_r <= psr_nxt;
      psr_stk_r <= psr_stk_nxt;
      pc_stk_r <= pc_stk_nxt;
      isp_r <= isp_nxt;
      vec_r <= vec_nxt;
      entry_lo_r <= entry_lo_nxt;
      wide_r <= wide_nxt;
      bus_req_r <= bus_req_nxt;
      bus_we_r <= bus_we_nxt;
      bus_byte_r <= bus_byte_nxt;
      bus_addr_r <= bus_addr_nxt;
      bus_wdata_r <= bus_wdata_nxt;
      exc_ack_r <= exc_ack_nxt;
      suspend_r <= suspend_nxt;
      done_r <= done_nxt;
      pc_load_r <= pc_load_nxt;
      pc_r <= pc_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign bus_req_o = bus_req_r;
  assign bus_we_o = bus_we_r;
  assign bus_byte_o = bus_byte_r;
  assign bus_addr_o = bus_addr_r;
  assign bus_wdata_o = bus_wdata_r;
  assign exc_ack_o = exc_ack_r;
  assign suspend_o = suspend_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign processor_status_word_o = psr_r;
  assign interrupt_stack_pointer_o = isp_r;
  assign pc_load_o = pc_load_r;
  assign pc_o = pc_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_sync_r);

  sequence seq_taken;
    state_r == ST_IDLE && (take_req || take_trace);
  endsequence

  sequence seq_psr_pushed;
    state_r == ST_PUSH_PSR && bus_ack_i;
  endsequence

  a_isp_frame: assert property (seq_taken |=> isp_r == $past(interrupt_stack_pointer_i) - FRAME_SIZE)
    else $error("stack pointer not lowered by six");
  a_psr_slot: assert property (seq_taken |=> bus_req_o && bus_we_o && bus_addr_o == isp_r + FRAME_PSR_OFS
                                             && bus_wdata_o == psr_stk_r)
    else $error("status word not written to highest frame word");
  a_psr_cleared: assert property (seq_psr_pushed |=> !psr_r[TRACE_PENDING_BIT_POS] && !psr_r[TRACE_ENABLE_BIT_POS] && !psr_r[USER_MODE_BIT_POS]
                                   && (psr_r[GLOBAL_INTERRUPT_MASK_BIT_POS] == ($past(psr_r[GLOBAL_INTERRUPT_MASK_BIT_POS]) && !$past(clear_mask))))
    else $error("status control bits not cleared after stacking");
  a_ack_maskable: assert property (bus_req_o && state_r == ST_ACK && kind_r == EXC_MASKABLE
                                    |-> bus_byte_o && !bus_we_o && bus_addr_o == ACK_MASKABLE)
    else $error("maskable acknowledge at wrong address");
  a_entry_addr: assert property (state_r == ST_READ_LO |-> bus_addr_o == table_base
                                  + (wide_r ? ADDR_W'({vec_r, 2'b00}) : ADDR_W'({vec_r, 1'b0})))
    else $error("dispatch entry read at wrong address");
  a_pc_even: assert property (done_o |-> pc_load_o && !pc_o[0])
    else $error("handler address bit 0 not cleared");
  a_narrow_top: assert property (done_o && !wide_r |-> pc_o[ADDR_W-1:WORD_W+1] == '0)
    else $error("narrow entry set high address bits");
  a_take_point: assert property (exc_ack_o && suspend_o |-> $past(!insn_boundary_i))
    else $error("trap suspended at an instruction boundary");
  a_stack_first: assert property (exc_ack_o |-> state_r == ST_PUSH_PSR ##1 state_r inside {ST_PUSH_PSR, ST_PUSH_PCL})
    else $error("stacking did not begin the sequence");
  a_trace_copy: assert property (state_r == ST_IDLE && insn_start_i && !take_req && !take_trace
                                  && !return_from_exception_i && !psr_wr_i
                                  |=> psr_r[TRACE_PENDING_BIT_POS] == $past(psr_r[TRACE_ENABLE_BIT_POS]))
    else $error("trace enable not copied at instruction start");

endmodule // exception_dispatch_unit

// >>> testbench/exc_bus_partner.sv
`timescale 1ns/1ps
module exc_bus_partner
  import exc_dispatch_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Bus from the dispatch unit
  input wire logic bus_req_i,
  input wire logic bus_we_i,
  input wire logic bus_byte_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [WORD_W-1:0] bus_wdata_i,
  output logic bus_ack_o,
  output logic [WORD_W-1:0] bus_rdata_o,
  // Behaviour controls
  input wire logic [1:0] stall_i,
  input wire logic [VEC_W-1:0] vector_i
);
  logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W+1:0] log_q [$];
  int wait_cnt = 0;

  initial begin
    bus_ack_o = 1'b0;
    bus_rdata_o = 16'h0000;
  end

  // Transfers complete at the edge that samples the ack; read data toggles when not valid.
  always @(posedge ref_clk_i) begin
    if (bus_ack_o && bus_req_i) begin
      log_q.push_back({bus_we_i, bus_byte_i, bus_addr_i});
      if (bus_we_i) mem[bus_addr_i] = bus_wdata_i;
    end
    #1;
    bus_ack_o = 1'b0;
    bus_rdata_o = ~bus_rdata_o;
    if (bus_req_i && wait_cnt < stall_i) wait_cnt++;
    else if (bus_req_i) begin
      wait_cnt = 0;
      bus_ack_o = 1'b1;
      if (bus_byte_i) bus_rdata_o = {8'hA5, vector_i};
      else if (!bus_we_i) bus_rdata_o = mem.exists(bus_addr_i) ? mem[bus_addr_i] : 16'hDEAD;
    end
  end
endmodule // exc_bus_partner

// >>> testbench/exception_dispatch_unit_bench.sv
`timescale 1ns/1ps
module exception_dispatch_unit_bench
  import exc_dispatch_pkg::*;
;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, insn_boundary_i = 1'b0, insn_start_i = 1'b0, exc_req_i = 1'b0;
  exc_kind_e exc_kind_i = EXC_NMI;
  logic [ADDR_W-1:0] cur_pc_i = 24'hABCDE2, next_pc_i = 24'hABCDE6, interrupt_stack_pointer_i = 24'h00F000;
  logic [WORD_W-1:0] dispatch_base_high_i = 16'h0001, dispatch_base_low_i = 16'h2340;
  logic dispatch_entry_width_select_i = 1'b0, alt_debug_ack_enable_i = 1'b0, alt_trace_ack_enable_i = 1'b0;
  logic alt_breakpoint_ack_enable_i = 1'b0, psr_wr_i = 1'b0, return_from_exception_i = 1'b0, bus_ack_i;
  logic [WORD_W-1:0] psr_wdata_i = 16'h0000, return_from_exception_global_interrupt_mask_bit = 16'h0000, bus_rdata_i, bus_wdata_o;
  logic [ADDR_W-1:0] return_from_exception_pc_i = 24'h000000, bus_addr_o, interrupt_stack_pointer_o, pc_o;
  logic bus_req_o, bus_we_o, bus_byte_o, exc_ack_o, suspend_o, busy_o, done_o, pc_load_o;
  logic [WORD_W-1:0] processor_status_word_o;
  logic [1:0] stall = 2'h0;
  logic [VEC_W-1:0] ic_vec = 8'h7F;
  int fails = 0, n_compared = 0;
  exc_kind_e kinds [11] = '{EXC_NMI, EXC_MASKABLE, EXC_EMU, EXC_TRACE, EXC_IAD, EXC_DEBUG, EXC_BPT, EXC_DVZ,
    EXC_FLG, EXC_SVC, EXC_UND};
  logic [VEC_W-1:0] vecs [11] = '{VEC_NMI, 8'h00, VEC_EMU, VEC_TRC, VEC_IAD, VEC_DBG, VEC_BPT, VEC_DVZ, VEC_FLG,
    VEC_SVC, VEC_UND};
  logic [ADDR_W-1:0] acks [11] = '{ACK_NMI, ACK_MASKABLE, ACK_EMU, ACK_ALT_TRACE, 24'h0, ACK_ALT_DEBUG,
    ACK_ALT_BPT, 24'h0, 24'h0, 24'h0, 24'h0};

  always #2.5 ref_clk_i = ~ref_clk_i;

  exception_dispatch_unit DUT (.*);

  exc_bus_partner P (.ref_clk_i(ref_clk_i), .bus_req_i(bus_req_o), .bus_we_i(bus_we_o), .bus_byte_i(bus_byte_o),
    .bus_addr_i(bus_addr_o), .bus_wdata_i(bus_wdata_o), .bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i),
    .stall_i(stall), .vector_i(ic_vec));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wait_high(input bit sel);
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while ((sel ? done_o : exc_ack_o) !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      print_verdict();
    end
  endtask

  // ---------------------------------------------------------------------------
  // One exception from request to handler address, then stack and bus order.
  // ---------------------------------------------------------------------------
  task automatic run_one(input int i, input bit wide);
    logic [ADDR_W-1:0] interrupt_stack_pointer, ent, spc, epc;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W+1:0] q [$];
    bit bnd, clr;
    bnd = i < 6;
    clr = i < 3 || i == 4 || i == 5;
    vec = (i == 1) ? ic_vec : vecs[i];
    spc = bnd ? next_pc_i : cur_pc_i;
    ent = {dispatch_base_high_i[7:0], dispatch_base_low_i} + (wide ? {14'h0, vec, 2'h0} : {15'h0, vec, 1'h0});
    epc = {wide ? 7'h55 : 7'h00, 8'h4E, vec, 1'b0};
    P.mem[ent] = {8'h4E, vec};
    P.mem[ent + 24'h000002] = 16'hFFD5;
    tick();
    interrupt_stack_pointer_i = interrupt_stack_pointer_i - 24'h000010;
    interrupt_stack_pointer = interrupt_stack_pointer_i;
    psr_wr_i = 1'b1;
    psr_wdata_i = 16'h0924;
    insn_boundary_i = bnd;
    dispatch_entry_width_select_i = wide;
    tick();
    psr_wr_i = 1'b0;
    exc_req_i = 1'b1;
    exc_kind_i = kinds[i];
    wait_high(1'b0);
    chk(suspend_o, !bnd);
    chk(interrupt_stack_pointer_o, interrupt_stack_pointer - 24'h000006);
    chk(busy_o, 1'b1);
    exc_req_i = 1'b0;
    wait_high(1'b1);
    chk(pc_load_o, 1'b1);
    chk(busy_o, 1'b0);
    chk(bus_req_o, 1'b0);
    chk(pc_o, epc);
    chk(processor_status_word_o, clr ? 16'h0020 : 16'h0820);
    chk(P.mem[interrupt_stack_pointer - 24'h000002], 16'h0924);
    chk(P.mem[interrupt_stack_pointer - 24'h000006], spc[15:0]);
    chk(P.mem[interrupt_stack_pointer - 24'h000004], {8'h00, spc[23:16]});
    q = '{{2'h2, interrupt_stack_pointer - 24'h000002}, {2'h2, interrupt_stack_pointer - 24'h000006}, {2'h2, interrupt_stack_pointer - 24'h000004}};
    if (i < 3 || (wide && acks[i] != 24'h0)) q.push_back({2'h1, acks[i]});
    q.push_back({2'h0, ent});
    if (wide) q.push_back({2'h0, ent + 24'h000002});
    chk(P.log_q.size(), q.size());
    foreach (q[k]) chk(P.log_q[k], q[k]);
    P.log_q.delete();
    $display("test kind %0d done", i);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    repeat (3) tick();
    exc_req_i = 1'b1;
    for (int j = 0; j < 8; j++) begin
      insn_boundary_i = j < 4;
      exc_kind_i = (j < 4) ? EXC_DVZ : EXC_MASKABLE;
      tick();
      chk(exc_ack_o, 1'b0);
    end
    exc_req_i = 1'b0;
    $display("test refusal done");
    for (int p = 0; p < 2; p++) begin
      stall = p ? 2'h2 : 2'h0;
      ic_vec = p ? 8'h10 : 8'h7F;
      {alt_debug_ack_enable_i, alt_trace_ack_enable_i, alt_breakpoint_ack_enable_i} = {3{p[0]}};
      for (int i = 0; i < 11; i++) run_one(i, p[0]);
    end
    tick();
    {alt_debug_ack_enable_i, alt_trace_ack_enable_i, alt_breakpoint_ack_enable_i} = 3'h0;
    {insn_boundary_i, dispatch_entry_width_select_i, psr_wr_i} = 3'h1;
    psr_wdata_i = 16'h0004;
    tick();
    {psr_wr_i, insn_start_i} = 2'h1;
    tick();
    insn_start_i = 1'b0;
    chk(processor_status_word_o, 16'h0006);
    P.mem[{dispatch_base_high_i[7:0], dispatch_base_low_i} + 24'h00000C] = 16'h1234;
    interrupt_stack_pointer_i = 24'h00E000;
    insn_boundary_i = 1'b1;
    wait_high(1'b0);
    wait_high(1'b1);
    chk(pc_o, 24'h002468);
    chk(P.mem[24'h00DFFE], 16'h0004);
    chk(processor_status_word_o, 16'h0000);
    $display("test trace done");
    tick();
    {insn_boundary_i, return_from_exception_i} = 2'h1;
    return_from_exception_pc_i = 24'h13579A;
    return_from_exception_global_interrupt_mask_bit = 16'h0800;
    tick();
    return_from_exception_i = 1'b0;
    chk(pc_load_o, 1'b1);
    chk(pc_o, 24'h13579A);
    chk(processor_status_word_o, 16'h0800);
    $display("test return done");
    print_verdict();
  end
endmodule // exception_dispatch_unit_bench
